// *** design/nad_alu.sv ***
// Summary of operation
// - zero_accumulator clears accumulator, updates zero flag
// - clear_carry/set_carry force carry, nothing else
// - invert_accumulator complements accumulator, updates zero
// - bump_up_accumulator adds one, updates zero, carry
// - bump_down_accumulator subtracts one, updates carry, zero
// - rotate left through carry, updates zero
// - copy_accumulator_to_aux copies, flags untouched
// - swap_accumulator_aux exchanges, flags untouched
// - bump_up_memory increments memory word, updates flags
// - bump_down_memory decrements memory word, updates flags
// - set/clear one memory bit chosen by field
// - sum_memory adds memory to accumulator, flags
// - sum with carry adds accumulator, carry, memory
// - decimal_fix_after_sum adds six, zero only
// - decimal_fix_after_diff adds ten, zero only
// - xor_memory exclusive-ORs memory into accumulator
// - memory AND into accumulator, zero only
// - memory OR into accumulator, zero only
// - compare_mem sets carry and zero by magnitude
// - every operation completes in four clocks
module nad_alu
  import nad_pkg::*;
#(
  parameter int unsigned DEPTH = DMEM_DEPTH,
  parameter int unsigned AW    = DMEM_AW
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             RESET,
  // Operation request from the sequencer
  input  wire logic             START,
  input  wire logic [4:0]       OP,
  input  wire logic [1:0]       BIT_SEL,
  input  wire logic [AW-1:0]    DATA_POINTER,
  output logic                  BUSY,
  output logic                  DONE,
  // Data memory side port
  input  wire logic             MEM_WE,
  input  wire logic [AW-1:0]    MEM_WADDR,
  input  wire logic [3:0]       MEM_WDATA,
  input  wire logic [AW-1:0]    MEM_RADDR,
  output logic      [3:0]       MEM_RDATA,
  // Architectural state
  output logic      [3:0]       ACC,
  output logic      [3:0]       AUX,
  output logic                  CARRY,
  output logic                  ZERO
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic                       busy;
    logic [1:0]                 phase;
    nad_op_t                    op;
    logic [1:0]                 bsel;
    logic [AW-1:0]              dp;
    logic [3:0]                 acc;
    logic [3:0]                 aux;
    logic                       cf;
    logic                       zf;
    logic                       done;
    logic [3:0]                 rdata;
    logic [DEPTH-1:0][3:0]      mem;
  } nad_state_t;

  nad_state_t s_q;
  nad_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Operands are sampled in the last phase so side-port writes cannot race
  always_comb begin
    logic [3:0] mword;
    logic [4:0] sum5;
    mword = s_q.mem[s_q.dp];
    sum5  = 5'h00;
    s_d   = s_q;
    s_d.done  = 1'b0;
    s_d.rdata = s_q.mem[MEM_RADDR];
    if (!s_q.busy) begin
      if (START) begin
        s_d.busy  = 1'b1;
        s_d.phase = FIRST_PHASE;
        s_d.op    = nad_op_t'(OP);
        s_d.bsel  = BIT_SEL;
        s_d.dp    = DATA_POINTER;
      end else if (MEM_WE) begin
        s_d.mem[MEM_WADDR] = MEM_WDATA; // Side writes only while idle
      end
    end else if (s_q.phase != LAST_PHASE) begin
      s_d.phase = s_q.phase + 2'h1;
    end else begin
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
      unique case (s_q.op)
        OP_ZERO_ACC: begin
          s_d.acc = 4'h0;
          s_d.zf  = 1'b1;
        end
        OP_CLEAR_CARRY: s_d.cf = 1'b0;
        OP_SET_CARRY:   s_d.cf = 1'b1;
        OP_INVERT_ACC: begin
          s_d.acc = ~s_q.acc;
          s_d.zf  = (s_d.acc == 4'h0);
        end
        OP_BUMP_UP_ACC, OP_BUMP_DN_ACC, OP_DEC_FIX_SUM, OP_DEC_FIX_DIF: begin
          unique case (s_q.op)
            OP_BUMP_UP_ACC: sum5 = {1'b0, s_q.acc} + {1'b0, ONE_VAL};
            OP_BUMP_DN_ACC: sum5 = {1'b0, s_q.acc} + {1'b0, MINUS_ONE_VAL};
            OP_DEC_FIX_SUM: sum5 = {1'b0, s_q.acc} + {1'b0, DEC_FIX_SUM_VAL};
            default:        sum5 = {1'b0, s_q.acc} + {1'b0, DEC_FIX_DIFF_VAL};
          endcase
          s_d.acc = sum5[3:0];
          s_d.zf  = (sum5[3:0] == 4'h0);
          // Decimal fixes leave carry alone; bump down carry means no borrow
          if (s_q.op == OP_BUMP_UP_ACC || s_q.op == OP_BUMP_DN_ACC) begin
            s_d.cf = sum5[4];
          end
        end
        OP_ROTATE_LEFT: begin
          s_d.acc = {s_q.acc[2:0], s_q.cf};
          s_d.cf  = s_q.acc[3];
          s_d.zf  = (s_d.acc == 4'h0);
        end
        OP_COPY_TO_AUX: s_d.aux = s_q.acc;
        OP_SWAP_AUX: begin
          s_d.acc = s_q.aux;
          s_d.aux = s_q.acc;
        end
        OP_BUMP_UP_MEM, OP_BUMP_DN_MEM: begin
          sum5 = (s_q.op == OP_BUMP_UP_MEM)
               ? {1'b0, mword} + {1'b0, ONE_VAL}
               : {1'b0, mword} + {1'b0, MINUS_ONE_VAL};
          s_d.mem[s_q.dp] = sum5[3:0];
          s_d.cf = sum5[4];
          s_d.zf = (sum5[3:0] == 4'h0);
        end
        OP_SET_MEM_BIT: s_d.mem[s_q.dp][s_q.bsel] = 1'b1;
        OP_CLR_MEM_BIT: s_d.mem[s_q.dp][s_q.bsel] = 1'b0;
        OP_SUM_MEM, OP_SUM_MEM_C: begin
          sum5 = {1'b0, s_q.acc} + {1'b0, mword}
               + {4'h0, (s_q.op == OP_SUM_MEM_C) & s_q.cf};
          s_d.acc = sum5[3:0];
          s_d.cf  = sum5[4];
          s_d.zf  = (sum5[3:0] == 4'h0);
        end
        OP_XOR_MEM: begin
          s_d.acc = s_q.acc ^ mword;
          s_d.zf  = ((s_q.acc ^ mword) == 4'h0);
        end
        OP_AND_MEM: begin
          s_d.acc = s_q.acc & mword;
          s_d.zf  = ((s_q.acc & mword) == 4'h0);
        end
        OP_OR_MEM: begin
          s_d.acc = s_q.acc | mword;
          s_d.zf  = ((s_q.acc | mword) == 4'h0);
        end
        OP_COMPARE_MEM: begin
          // Result is discarded; only the flags tell the magnitude
          sum5 = {1'b0, ~mword} + {1'b0, s_q.acc} + {4'h0, 1'b1};
          s_d.cf = sum5[4];
          s_d.zf = (sum5[3:0] == 4'h0);
        end
        default: ; // Unassigned op codes just burn the instruction cycle
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register

  // Memory contents are not cleared by reset, as in a real RAM
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_q.busy  <= 1'b0;
      s_q.phase <= 2'h0;
      s_q.op    <= OP_ZERO_ACC;
      s_q.bsel  <= 2'h0;
      s_q.dp    <= '0;
      s_q.acc   <= ACC_RST;
      s_q.aux   <= AUX_RST;
      s_q.cf    <= CARRY_RST;
      s_q.zf    <= ZERO_RST;
      s_q.done  <= 1'b0;
      s_q.rdata <= 4'h0;
      s_q.mem   <= s_q.mem; // Hold, so a commit pending at reset never lands
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign BUSY      = s_q.busy;
  assign DONE      = s_q.done;
  assign MEM_RDATA = s_q.rdata;
  assign ACC       = s_q.acc;
  assign AUX       = s_q.aux;
  assign CARRY     = s_q.cf;
  assign ZERO      = s_q.zf;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  logic [3:0] cur_mem;
  assign cur_mem = s_q.mem[s_q.dp];

  sequence seq_take;
    START && !BUSY;
  endsequence

  sequence seq_commit(nad_op_t o);
    BUSY && s_q.phase == LAST_PHASE && s_q.op == o;
  endsequence

  a_insn_cycle_len: assert property (seq_take |=> !DONE [*3] ##1 DONE)
    else $error("operation did not finish in four clocks");

  a_zero_acc: assert property (seq_commit(OP_ZERO_ACC) |=> ACC == 4'h0 && ZERO)
    else $error("zero_accumulator result wrong");

  a_carry_force: assert property (seq_commit(OP_SET_CARRY) |=>
      CARRY && $stable(ACC) && $stable(ZERO) && $stable(AUX))
    else $error("set_carry wrong or disturbed state");

  a_invert_acc: assert property (seq_commit(OP_INVERT_ACC) |=>
      ACC == ~$past(ACC) && ZERO == ($past(ACC) == 4'hf))
    else $error("invert_accumulator result wrong");

  a_bump_up_acc: assert property (seq_commit(OP_BUMP_UP_ACC) |=>
      {CARRY, ACC} == {1'b0, $past(ACC)} + 5'h01)
    else $error("bump_up_accumulator result wrong");

  a_bump_dn_acc: assert property (seq_commit(OP_BUMP_DN_ACC) |=>
      ACC == $past(ACC) - 4'h1 && CARRY == ($past(ACC) != 4'h0))
    else $error("bump_down_accumulator result wrong");

  a_rotate_left: assert property (seq_commit(OP_ROTATE_LEFT) |=>
      ACC == {$past(ACC[2:0]), $past(CARRY)} && CARRY == $past(ACC[3]))
    else $error("rotate_left_through_carry result wrong");

  a_copy_aux: assert property (seq_commit(OP_COPY_TO_AUX) |=>
      AUX == ACC && $stable(ACC) && $stable(CARRY) && $stable(ZERO))
    else $error("copy_accumulator_to_aux wrong");

  a_swap_aux: assert property (seq_commit(OP_SWAP_AUX) |=>
      ACC == $past(AUX) && AUX == $past(ACC) && $stable(CARRY))
    else $error("swap_accumulator_aux wrong");

  a_bump_up_mem: assert property (seq_commit(OP_BUMP_UP_MEM) |=>
      {CARRY, cur_mem} == {1'b0, $past(cur_mem)} + 5'h01)
    else $error("bump_up_memory result wrong");

  a_bump_dn_mem: assert property (seq_commit(OP_BUMP_DN_MEM) |=>
      cur_mem == $past(cur_mem) - 4'h1 && ZERO == (cur_mem == 4'h0))
    else $error("bump_down_memory result wrong");

  a_set_mem_bit: assert property (seq_commit(OP_SET_MEM_BIT) |=>
      cur_mem == ($past(cur_mem) | (4'h1 << $past(s_q.bsel))))
    else $error("set_memory_bit result wrong");

  a_sum_mem_c: assert property (seq_commit(OP_SUM_MEM_C) |=>
      {CARRY, ACC} == {1'b0, $past(ACC)} + {1'b0, $past(cur_mem)} + $past(CARRY))
    else $error("sum_memory_with_carry result wrong");

  a_dec_fix_sum: assert property (seq_commit(OP_DEC_FIX_SUM) |=>
      ACC == $past(ACC) + 4'h6 && $stable(CARRY))
    else $error("decimal_fix_after_sum result wrong");

  a_and_mem: assert property (seq_commit(OP_AND_MEM) |=>
      ACC == ($past(ACC) & $past(cur_mem)) && ZERO == (ACC == 4'h0))
    else $error("memory AND result wrong");

  a_compare_mem: assert property (seq_commit(OP_COMPARE_MEM) |=>
      $stable(ACC) && CARRY == ($past(cur_mem) <= ACC)
      && ZERO == ($past(cur_mem) == ACC))
    else $error("compare_mem flags wrong");

  a_clear_carry: assert property (seq_commit(OP_CLEAR_CARRY) |=>
      !CARRY && $stable(ACC) && $stable(ZERO) && $stable(AUX))
    else $error("clear_carry wrong or disturbed state");

  a_clr_mem_bit: assert property (seq_commit(OP_CLR_MEM_BIT) |=>
      cur_mem == ($past(cur_mem) & ~(4'h1 << $past(s_q.bsel))))
    else $error("clear_memory_bit result wrong");

  a_sum_mem: assert property (seq_commit(OP_SUM_MEM) |=>
      {CARRY, ACC} == {1'b0, $past(ACC)} + {1'b0, $past(cur_mem)} && ZERO == (ACC == 4'h0))
    else $error("sum_memory result wrong");

  a_or_mem: assert property (seq_commit(OP_OR_MEM) |=>
      ACC == ($past(ACC) | $past(cur_mem)) && $stable(CARRY))
    else $error("memory OR result wrong");

endmodule : nad_alu

// *** design/nad_pkg.sv ***
package nad_pkg;

  // Datapath word width: accumulator, aux register and memory words
  localparam int unsigned WORD_W           = 4;
  localparam int unsigned DMEM_DEPTH       = 256;
  localparam int unsigned DMEM_AW          = 8;

  // Timing: one instruction cycle is four system clock periods
  localparam int unsigned SYS_CLK_PERIOD_NS = 4;
  localparam int unsigned INSN_CLK_PERIODS  = 4;
  localparam int unsigned INSN_CYCLES       = INSN_CLK_PERIODS;
  localparam logic [1:0]  LAST_PHASE        = 2'(INSN_CYCLES - 1);
  localparam logic [1:0]  FIRST_PHASE       = 2'h1;

  // Constants used by the arithmetic ops
  localparam logic [3:0]  ONE_VAL          = 4'h1;
  localparam logic [3:0]  MINUS_ONE_VAL    = 4'hf;
  localparam logic [3:0]  DEC_FIX_SUM_VAL  = 4'h6;
  localparam logic [3:0]  DEC_FIX_DIFF_VAL = 4'ha;

  // Reset values of the architectural state
  localparam logic [3:0]  ACC_RST          = 4'h0;
  localparam logic [3:0]  AUX_RST          = 4'h0;
  localparam logic        CARRY_RST        = 1'b0;
  localparam logic        ZERO_RST         = 1'b1;

  // Decoded operations handed over by the instruction sequencer
  typedef enum logic [4:0] {
    OP_ZERO_ACC    = 5'b00000,
    OP_CLEAR_CARRY = 5'b00001,
    OP_SET_CARRY   = 5'b00010,
    OP_INVERT_ACC  = 5'b00011,
    OP_BUMP_UP_ACC = 5'b00100,
    OP_BUMP_DN_ACC = 5'b00101,
    OP_ROTATE_LEFT = 5'b00110,
    OP_COPY_TO_AUX = 5'b00111,
    OP_SWAP_AUX    = 5'b01000,
    OP_BUMP_UP_MEM = 5'b01001,
    OP_BUMP_DN_MEM = 5'b01010,
    OP_SET_MEM_BIT = 5'b01011,
    OP_CLR_MEM_BIT = 5'b01100,
    OP_SUM_MEM     = 5'b01101,
    OP_SUM_MEM_C   = 5'b01110,
    OP_DEC_FIX_SUM = 5'b01111,
    OP_DEC_FIX_DIF = 5'b10000,
    OP_XOR_MEM     = 5'b10001,
    OP_AND_MEM     = 5'b10010,
    OP_OR_MEM      = 5'b10011,
    OP_COMPARE_MEM = 5'b10100
  } nad_op_t;

endpackage : nad_pkg

// *** dv/nad_alu_bench.sv ***
module nad_alu_bench import nad_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk, reset, start, mem_we, busy, done, carry, zero;
  logic [4:0] op;
  logic [1:0] bit_sel;
  logic [7:0] data_pointer, mem_waddr, mem_raddr;
  logic [3:0] mem_wdata, mem_rdata, acc_o, aux_o;
  int         errors, checked, acc, aux, cf, zf, n;
  int         mem [256];
  nad_op_t    dir_ops [15] = '{OP_ZERO_ACC, OP_BUMP_DN_ACC, OP_BUMP_UP_ACC, OP_COMPARE_MEM,
    OP_SET_CARRY, OP_ROTATE_LEFT, OP_INVERT_ACC, OP_COPY_TO_AUX, OP_SWAP_AUX, OP_CLEAR_CARRY,
    OP_SUM_MEM_C, OP_DEC_FIX_SUM, OP_DEC_FIX_DIF, OP_BUMP_UP_MEM, OP_BUMP_DN_MEM};

  nad_alu dut (.CLK(clk), .RESET(reset), .START(start), .OP(op), .BIT_SEL(bit_sel),
    .DATA_POINTER(data_pointer), .BUSY(busy), .DONE(done), .MEM_WE(mem_we),
    .MEM_WADDR(mem_waddr), .MEM_WDATA(mem_wdata), .MEM_RADDR(mem_raddr),
    .MEM_RDATA(mem_rdata), .ACC(acc_o), .AUX(aux_o), .CARRY(carry), .ZERO(zero));

  // Free-running system clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checked %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  // Architectural state against the integer model
  task automatic check_state;
    check({4'h0, acc_o}, 8'(acc), "acc");
    check({4'h0, aux_o}, 8'(aux), "aux");
    check({7'h0, carry}, 8'(cf), "carry");
    check({7'h0, zero}, 8'(zf), "zero");
  endtask : check_state

  // Reset is held 6 cycles; memory survives, so the model keeps it too
  task automatic do_reset;
    @(posedge clk);
    #1 reset = 1'b1;
    start = 1'b0;
    mem_we = 1'b0;
    repeat (6) @(posedge clk);
    #1 acc = 0;
    aux = 0;
    cf = 0;
    zf = 1;
    check_state();
    check({6'h0, busy, done}, 8'h00, "busy/done in reset");
    check({4'h0, mem_rdata}, 8'h00, "read data in reset");
    reset = 1'b0;
    $display("test reset done");
  endtask : do_reset

  // Behavioural model; a result r >= 0 lands in the accumulator with zero updated
  task automatic model(input logic [4:0] o, input int b, input int dp);
    int m, r, t;
    m = mem[dp];
    r = -1;
    case (o)
      OP_ZERO_ACC:    r = 0;
      OP_CLEAR_CARRY: cf = 0;
      OP_SET_CARRY:   cf = 1;
      OP_INVERT_ACC:  r = ~acc & 15;
      OP_BUMP_UP_ACC: begin r = acc + 1; cf = r >> 4; end
      OP_BUMP_DN_ACC: begin r = acc + 15; cf = r >> 4; end
      OP_ROTATE_LEFT: begin r = (acc << 1) | cf; cf = r >> 4; end
      OP_COPY_TO_AUX: aux = acc;
      OP_SWAP_AUX:    begin t = aux; aux = acc; acc = t; end
      OP_BUMP_UP_MEM: begin mem[dp] = (m + 1) & 15; cf = (m + 1) >> 4; zf = m == 15; end
      OP_BUMP_DN_MEM: begin mem[dp] = (m + 15) & 15; cf = m != 0; zf = m == 1; end
      OP_SET_MEM_BIT: mem[dp] = m | (1 << b);
      OP_CLR_MEM_BIT: mem[dp] = m & ~(1 << b) & 15;
      OP_SUM_MEM:     begin r = acc + m; cf = r >> 4; end
      OP_SUM_MEM_C:   begin r = acc + m + cf; cf = r >> 4; end
      OP_DEC_FIX_SUM: r = acc + 6;
      OP_DEC_FIX_DIF: r = acc + 10;
      OP_XOR_MEM:     r = acc ^ m;
      OP_AND_MEM:     r = acc & m;
      OP_OR_MEM:      r = acc | m;
      OP_COMPARE_MEM: begin cf = m <= acc; zf = m == acc; end
      default: ;
    endcase
    if (r >= 0) begin
      acc = r & 15;
      zf = acc == 0;
    end
  endtask : model

  // One operation; with junk set, START and a side write are held while busy and must be ignored
  task automatic run_op(input logic [4:0] o, input logic [1:0] b, input logic [7:0] dp,
                        input bit junk);
    start = 1'b1;
    op = o;
    bit_sel = b;
    data_pointer = dp;
    mem_raddr = dp;
    @(posedge clk);
    #1 check({7'h0, busy}, 8'h01, "busy after take");
    model(o, int'(b), int'(dp));
    if (junk) begin
      op = o ^ 5'h01;
      mem_we = 1'b1;
      mem_waddr = dp;
      mem_wdata = ~4'(mem[dp]);
    end else start = 1'b0;
    n = 0;
    while (n < 8 && done !== 1'b1) begin
      @(posedge clk);
      #1 n++;
    end
    start = 1'b0;
    mem_we = 1'b0;
    if (n == 8) begin
      errors++;
      $display("mismatch at %0t: done never came", $time);
      finish_test();
    end else begin
      check(8'(n), 8'h03, "latency");
      check_state();
      @(posedge clk);
      #1 check({7'h0, done}, 8'h00, "done pulse");
      check({4'h0, mem_rdata}, 8'(mem[dp]), "memory word");
    end
  endtask : run_op

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: preload, directed boundaries, random stream, reset mid-run
  initial begin
    reset = 1'b1;
    start = 1'b0;
    op = 5'h00;
    bit_sel = 2'h0;
    data_pointer = 8'h00;
    mem_we = 1'b0;
    mem_waddr = 8'h00;
    mem_wdata = 4'h0;
    mem_raddr = 8'h00;
    errors = 0;
    checked = 0;
    void'($urandom(30440));
    do_reset();
    for (int i = 0; i < 9; i++) begin
      mem_we = 1'b1;
      mem_waddr = (i == 8) ? 8'hff : 8'(i);
      mem_wdata = (i == 8) ? 4'hf : 4'($urandom_range(15, 0));
      @(posedge clk);
      #1 mem[mem_waddr] = int'(mem_wdata);
    end
    mem_we = 1'b0;
    // Wrap of 0 and 15 in both directions on accumulator and memory
    foreach (dir_ops[i]) run_op(dir_ops[i], 2'h0, 8'hff, 1'b0);
    $display("test directed done");
    for (int i = 0; i < 400; i++) begin
      run_op(5'($urandom_range(23, 0)), 2'($urandom_range(3, 0)),
             ($urandom_range(8, 0) == 8) ? 8'hff : 8'($urandom_range(7, 0)),
             $urandom_range(3, 0) == 0);
    end
    $display("test random done");
    do_reset();
    run_op(OP_BUMP_UP_MEM, 2'h0, 8'h02, 1'b1);
    $display("test after reset done");
    finish_test();
  end

endmodule : nad_alu_bench
